// [sfr_pkg.sv]
// Constants for the flash pin-function, reset and address-map block.
// Assumes a 50 MHz ref_clk and a serial clock well below a quarter of it.
package sfr_pkg;

  // Clock and reset pulse timing
  localparam int unsigned REF_CLK_MHZ            = 50;
  localparam int unsigned RESTART_PULSE_MIN_NS   = 1000;
  localparam int unsigned RESTART_PULSE_CYC      =
    (RESTART_PULSE_MIN_NS * REF_CLK_MHZ + 999) / 1000;
  localparam logic [6:0]  RESTART_CNT_MAX        = 7'(RESTART_PULSE_CYC);

  // Array geometry
  localparam int unsigned ARRAY_ADDR_W  = 22;
  localparam int unsigned LINK_ADDR_W   = 24;
  localparam int unsigned SECTOR_LSB    = 12;
  localparam int unsigned BLOCK_LSB     = 16;
  localparam int unsigned PAGE_LSB      = 8;
  localparam int unsigned SEC_SEL_MSB   = 13;

  // Parameter space map
  localparam logic [7:0] PARAM_HDR_BASE  = 8'h00;
  localparam logic [7:0] PARAM_TBL_BASE  = 8'h30;
  localparam logic [7:0] PARAM_LAST      = 8'h6F;
  localparam logic [7:0] PARAM_RSVD_DATA = 8'hFF;

  // Instruction codes
  localparam logic [7:0] CMD_READ_PARAM   = 8'h5A;
  localparam logic [7:0] CMD_PAGE_PROG    = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'hC7;
  localparam logic [7:0] CMD_SEC_ERASE    = 8'h44;
  localparam logic [7:0] CMD_SEC_PROG     = 8'h42;

  // Bit counts on the link
  localparam logic [4:0] LAST_CMD_BIT   = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT  = 5'h17;
  localparam logic [4:0] LAST_DUMMY_BIT = 5'h07;
  localparam logic [4:0] LAST_DATA_BIT  = 5'h07;

  // Operation kinds handed to the array controller
  typedef enum logic [2:0] {
    OP_NONE       = 3'h0,
    OP_PAGE_PROG  = 3'h1,
    OP_SECT_ERASE = 3'h2,
    OP_BLK_ERASE  = 3'h3,
    OP_CHIP_ERASE = 3'h4,
    OP_SEC_ERASE  = 3'h5,
    OP_SEC_PROG   = 3'h6
  } sfr_op_t;

  // Link engine states
  typedef enum logic [6:0] {
    ST_WAIT  = 7'h01,
    ST_IDLE  = 7'h02,
    ST_CMD   = 7'h04,
    ST_ADDR  = 7'h08,
    ST_DUMMY = 7'h10,
    ST_RDOUT = 7'h20,
    ST_WRIN  = 7'h40
  } sfr_state_t;

endpackage : sfr_pkg

// [sfr_param_rom.sv]
// Parameter space contents, 256 bytes, registered read data.
// Assumes the address is held stable for one clock before use.
`timescale 1ns/1ps
module sfr_param_rom #(
  // Arbitrary neutral maker code
  parameter logic [7:0] MAKER_CODE = 8'hA5
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Read port
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data_ff
);

  logic [7:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = sfr_pkg::PARAM_RSVD_DATA;
    if (rd_addr <= sfr_pkg::PARAM_LAST) begin
      unique case (rd_addr)
        8'h00: nxt_rd_data = 8'h53;
        8'h01: nxt_rd_data = 8'h46;
        8'h02: nxt_rd_data = 8'h44;
        8'h03: nxt_rd_data = 8'h50;
        8'h05: nxt_rd_data = 8'h01;
        8'h06: nxt_rd_data = 8'h01;
        8'h0A: nxt_rd_data = 8'h01;
        8'h0B: nxt_rd_data = 8'h09;
        8'h0C: nxt_rd_data = sfr_pkg::PARAM_TBL_BASE;
        8'h10: nxt_rd_data = MAKER_CODE;
        8'h12: nxt_rd_data = 8'h01;
        8'h13: nxt_rd_data = 8'h04;
        8'h14: nxt_rd_data = 8'h60;
        8'h30: nxt_rd_data = 8'hE5;
        8'h31: nxt_rd_data = sfr_pkg::CMD_SECTOR_ERASE;
        8'h04, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h11, 8'h15, 8'h16:
          nxt_rd_data = 8'h00;
        default: nxt_rd_data = sfr_pkg::PARAM_RSVD_DATA;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

endmodule : sfr_param_rom

// [sfr_core.sv]
// Serial link front end of the flash: shared pin 3 function, hardware
// restart, pause, address map decode and parameter-space reads.
// Assumes link pins are asynchronous to ref_clk; mode-0 serial clock
// slower than ref_clk/4; status bits come from same-clock logic.
`timescale 1ns/1ps
module sfr_core (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Link pins
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic        serial_in_pin,
  input  wire logic        quad_data_line_three,
  output logic             so_pin_ff,
  output logic             so_oe_n_ff,
  // Status bits
  input  wire logic        pin_function_select_bit,
  input  wire logic        quad_enable_bit,
  input  wire logic [3:1]  sec_lock_bits,
  // Array controller side
  output logic             abort_ff,
  output logic             paused_ff,
  output logic             op_valid_ff,
  output sfr_pkg::sfr_op_t op_kind_ff,
  output logic [21:0]      op_addr_ff,
  output logic [1:0]       op_sec_idx_ff,
  output logic [7:0]       op_clr_mask_ff,
  output logic             op_refused_ff
);

  // Synchronisers; select starts low so a real deselect is seen first
  logic [1:0] cs_sync_ff;
  logic [1:0] sclk_sync_ff;
  logic [1:0] si_sync_ff;
  logic [1:0] io3_sync_ff;
  logic       sclk_dly_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cs_sync_ff   <= 2'h0;
      sclk_sync_ff <= 2'h0;
      si_sync_ff   <= 2'h0;
      io3_sync_ff  <= 2'h3;
      sclk_dly_ff  <= 1'b0;
    end else begin
      cs_sync_ff   <= {cs_sync_ff[0], cs_n_pin};
      sclk_sync_ff <= {sclk_sync_ff[0], sclk_pin};
      si_sync_ff   <= {si_sync_ff[0], serial_in_pin};
      io3_sync_ff  <= {io3_sync_ff[0], quad_data_line_three};
      sclk_dly_ff  <= sclk_sync_ff[1];
    end
  end

  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic io3_s;
  assign cs_n_s = cs_sync_ff[1];
  assign sclk_s = sclk_sync_ff[1];
  assign si_s   = si_sync_ff[1];
  assign io3_s  = io3_sync_ff[1];

  // Pin 3 function decode
  logic restart_fn;
  logic pause_fn;
  logic paused;
  // restart only when quad off and select set
  assign restart_fn = ~quad_enable_bit & pin_function_select_bit;
  assign pause_fn   = ~quad_enable_bit & ~pin_function_select_bit;
  assign paused     = pause_fn & ~io3_s & ~cs_n_s;

  // Edges are ignored while paused, so clock toggles during pause are lost
  logic rise;
  logic fall;
  assign rise = sclk_s & ~sclk_dly_ff & ~paused;
  assign fall = ~sclk_s & sclk_dly_ff & ~paused;

  // Restart pulse width measurement
  logic [6:0] rst_cnt_ff;
  logic       restart_hit;
  logic       restart_hold;
  assign restart_hold = restart_fn & ~io3_s;
  assign restart_hit  = restart_hold & (rst_cnt_ff == sfr_pkg::RESTART_CNT_MAX - 7'h01);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_cnt_ff <= 7'h00;
    end else if (!restart_hold) begin
      rst_cnt_ff <= 7'h00;
    end else if (rst_cnt_ff != sfr_pkg::RESTART_CNT_MAX) begin
      rst_cnt_ff <= rst_cnt_ff + 7'h01;
    end
  end
  logic restart_active;
  assign restart_active = restart_hit | (rst_cnt_ff == sfr_pkg::RESTART_CNT_MAX);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      abort_ff  <= 1'b0;
      paused_ff <= 1'b0;
    end else begin
      abort_ff  <= restart_hit;
      paused_ff <= paused;
    end
  end

  // Link engine
  sfr_pkg::sfr_state_t st_ff;
  logic [4:0]  bit_cnt_ff;
  logic [7:0]  cmd_ff;
  logic [23:0] in_sh_ff;

  logic [7:0]  cmd_byte;
  logic [23:0] addr_word;
  logic [7:0]  data_byte;
  logic        cmd_done;
  logic        addr_done;
  logic        data_done;
  assign cmd_byte  = {in_sh_ff[6:0], si_s};
  assign addr_word = {in_sh_ff[22:0], si_s};
  assign data_byte = {in_sh_ff[6:0], si_s};
  assign cmd_done  = rise & (st_ff == sfr_pkg::ST_CMD) & (bit_cnt_ff == sfr_pkg::LAST_CMD_BIT);
  assign addr_done = rise & (st_ff == sfr_pkg::ST_ADDR) & (bit_cnt_ff == sfr_pkg::LAST_ADDR_BIT);
  assign data_done = rise & (st_ff == sfr_pkg::ST_WRIN) & (bit_cnt_ff == sfr_pkg::LAST_DATA_BIT);

  logic cmd_has_addr;
  always_comb begin
    cmd_has_addr = 1'b0;
    // no page erase code is decoded
    if (cmd_byte == sfr_pkg::CMD_READ_PARAM || cmd_byte == sfr_pkg::CMD_PAGE_PROG ||
        cmd_byte == sfr_pkg::CMD_SECTOR_ERASE || cmd_byte == sfr_pkg::CMD_BLOCK_ERASE ||
        cmd_byte == sfr_pkg::CMD_SEC_ERASE || cmd_byte == sfr_pkg::CMD_SEC_PROG) begin
      cmd_has_addr = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // power-up waits for a deselect first
      st_ff      <= sfr_pkg::ST_WAIT;
      bit_cnt_ff <= 5'h00;
      cmd_ff     <= 8'h00;
      in_sh_ff   <= 24'h000000;
    end else if (restart_active) begin
      // drop partial command, await fresh select
      st_ff      <= sfr_pkg::ST_WAIT;
      bit_cnt_ff <= 5'h00;
    end else if (st_ff == sfr_pkg::ST_WAIT) begin
      if (cs_n_s) begin
        st_ff <= sfr_pkg::ST_IDLE;
      end
    end else if (cs_n_s) begin
      st_ff <= sfr_pkg::ST_IDLE;
    end else if (st_ff == sfr_pkg::ST_IDLE) begin
      st_ff      <= sfr_pkg::ST_CMD;
      bit_cnt_ff <= 5'h00;
    end else if (rise) begin
      in_sh_ff   <= addr_word;
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      unique case (st_ff)
        sfr_pkg::ST_CMD: begin
          if (cmd_done) begin
            cmd_ff     <= cmd_byte;
            bit_cnt_ff <= 5'h00;
            st_ff      <= cmd_has_addr ? sfr_pkg::ST_ADDR : sfr_pkg::ST_WAIT;
          end
        end
        sfr_pkg::ST_ADDR: begin
          if (addr_done) begin
            bit_cnt_ff <= 5'h00;
            // parameter read takes a dummy byte
            if (cmd_ff == sfr_pkg::CMD_READ_PARAM) begin
              st_ff <= sfr_pkg::ST_DUMMY;
            end else if (cmd_ff == sfr_pkg::CMD_PAGE_PROG ||
                         cmd_ff == sfr_pkg::CMD_SEC_PROG) begin
              st_ff <= sfr_pkg::ST_WRIN;
            end else begin
              st_ff <= sfr_pkg::ST_WAIT;
            end
          end
        end
        sfr_pkg::ST_DUMMY: begin
          if (bit_cnt_ff == sfr_pkg::LAST_DUMMY_BIT) begin
            st_ff <= sfr_pkg::ST_RDOUT;
          end
        end
        sfr_pkg::ST_WRIN: begin
          if (data_done) begin
            bit_cnt_ff <= 5'h00;
          end
        end
        sfr_pkg::ST_RDOUT: bit_cnt_ff <= 5'h00;
        default: st_ff <= sfr_pkg::ST_WAIT;
      endcase
    end
  end

  // Address decode for array and security registers
  logic [23:0] base_addr_ff;
  logic [7:0]  byte_idx_ff;

  // byte index wraps inside its 256-byte page
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      base_addr_ff <= 24'h000000;
      byte_idx_ff  <= 8'h00;
    end else if (addr_done) begin
      base_addr_ff <= addr_word;
      byte_idx_ff  <= addr_word[7:0];
    end else if (data_done) begin
      byte_idx_ff <= byte_idx_ff + 8'h01;
    end
  end

  function automatic logic [1:0] sec_index(input logic [23:0] a);
    sec_index = a[sfr_pkg::SEC_SEL_MSB:sfr_pkg::SECTOR_LSB];
  endfunction : sec_index

  // only x000h..x0FFh of registers 0..3 exist
  function automatic logic sec_in_map(input logic [23:0] a);
    sec_in_map = (a[23:sfr_pkg::SEC_SEL_MSB+1] == '0) &&
                 (a[sfr_pkg::SECTOR_LSB-1:sfr_pkg::PAGE_LSB] == '0);
  endfunction : sec_in_map

  logic        sec_grant;
  logic [1:0]  sec_idx;
  logic [23:0] sec_addr;
  always_comb begin
    sec_addr  = addr_done ? addr_word : base_addr_ff;
    sec_idx   = sec_index(sec_addr);
    sec_grant = 1'b0;
    // register 0 is the read-only parameter store
    // each lock guards its own register only
    if (sec_in_map(sec_addr) && sec_idx != 2'h0) begin
      sec_grant = ~sec_lock_bits[sec_idx];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      op_valid_ff    <= 1'b0;
      op_refused_ff  <= 1'b0;
      op_kind_ff     <= sfr_pkg::OP_NONE;
      op_addr_ff     <= 22'h000000;
      op_sec_idx_ff  <= 2'h0;
      op_clr_mask_ff <= 8'h00;
    end else begin
      op_valid_ff   <= 1'b0;
      op_refused_ff <= 1'b0;
      if (cmd_done && cmd_byte == sfr_pkg::CMD_CHIP_ERASE) begin
        op_valid_ff <= 1'b1;
        op_kind_ff  <= sfr_pkg::OP_CHIP_ERASE;
        op_addr_ff  <= 22'h000000;
      end else if (addr_done) begin
        unique case (cmd_ff)
          sfr_pkg::CMD_SECTOR_ERASE: begin
            op_valid_ff <= 1'b1;
            op_kind_ff  <= sfr_pkg::OP_SECT_ERASE;
            op_addr_ff  <= {addr_word[21:sfr_pkg::SECTOR_LSB], 12'h000};
          end
          sfr_pkg::CMD_BLOCK_ERASE: begin
            op_valid_ff <= 1'b1;
            op_kind_ff  <= sfr_pkg::OP_BLK_ERASE;
            op_addr_ff  <= {addr_word[21:sfr_pkg::BLOCK_LSB], 16'h0000};
          end
          sfr_pkg::CMD_SEC_ERASE: begin
            op_valid_ff   <= sec_grant;
            op_refused_ff <= ~sec_grant;
            op_kind_ff    <= sfr_pkg::OP_SEC_ERASE;
            op_sec_idx_ff <= sec_idx;
            op_addr_ff    <= {addr_word[21:sfr_pkg::PAGE_LSB], 8'h00};
          end
          default: op_kind_ff <= op_kind_ff;
        endcase
      end else if (data_done) begin
        // program only clears the zero bits
        op_clr_mask_ff <= ~data_byte;
        op_addr_ff     <= {base_addr_ff[21:sfr_pkg::PAGE_LSB], byte_idx_ff};
        if (cmd_ff == sfr_pkg::CMD_SEC_PROG) begin
          op_valid_ff   <= sec_grant;
          op_refused_ff <= ~sec_grant;
          op_kind_ff    <= sfr_pkg::OP_SEC_PROG;
          op_sec_idx_ff <= sec_idx;
        end else begin
          op_valid_ff <= 1'b1;
          op_kind_ff  <= sfr_pkg::OP_PAGE_PROG;
        end
      end
    end
  end

  // Parameter space read path
  logic [7:0] rom_addr_ff;
  logic [7:0] rom_data;
  logic [7:0] out_sh_ff;
  logic [2:0] out_cnt_ff;
  logic       rd_active;
  assign rd_active = (st_ff == sfr_pkg::ST_RDOUT) & ~cs_n_s & ~restart_active;

  sfr_param_rom u_param_rom (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .rd_addr    (rom_addr_ff),
    .rd_data_ff (rom_data)
  );

  // output byte at the requested address, shifted out on falls
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rom_addr_ff <= sfr_pkg::PARAM_HDR_BASE;
      out_sh_ff   <= 8'h00;
      out_cnt_ff  <= 3'h0;
      so_pin_ff   <= 1'b0;
    end else if (addr_done) begin
      rom_addr_ff <= addr_word[7:0];
      out_cnt_ff  <= 3'h0;
    end else if (rd_active && fall) begin
      out_cnt_ff <= out_cnt_ff + 3'h1;
      if (out_cnt_ff == 3'h0) begin
        so_pin_ff   <= rom_data[7];
        out_sh_ff   <= {rom_data[6:0], 1'b0};
        rom_addr_ff <= rom_addr_ff + 8'h01;
      end else begin
        so_pin_ff <= out_sh_ff[7];
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      end
    end
  end

  // output floats while paused or deselected
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      so_oe_n_ff <= 1'b1;
    end else begin
      so_oe_n_ff <= ~(rd_active & ~paused);
    end
  end
endmodule : sfr_core

// [sfr_core_chk.sv]
// Checker for restart, pause and operation outputs of sfr_core.
// Assumes one ref_clk domain; attached by the bind at the foot.
`timescale 1ns/1ps
module sfr_core_chk (
  // Clock and reset
  input wire logic             ref_clk,
  input wire logic             rstn,
  // Link pins
  input wire logic             cs_n_pin,
  input wire logic             sclk_pin,
  input wire logic             serial_in_pin,
  input wire logic             quad_data_line_three,
  input wire logic             so_pin_ff,
  input wire logic             so_oe_n_ff,
  // Status bits
  input wire logic             pin_function_select_bit,
  input wire logic             quad_enable_bit,
  input wire logic [3:1]       sec_lock_bits,
  // Array controller side
  input wire logic             abort_ff,
  input wire logic             paused_ff,
  input wire logic             op_valid_ff,
  input wire sfr_pkg::sfr_op_t op_kind_ff,
  input wire logic [21:0]      op_addr_ff,
  input wire logic [1:0]       op_sec_idx_ff,
  input wire logic [7:0]       op_clr_mask_ff,
  input wire logic             op_refused_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  abort_pulse_a: assert property (abort_ff |=> !abort_ff)
    else $error("abort pulse longer than one cycle");
  abort_cause_a: assert property (abort_ff |-> $past(pin_function_select_bit)
    && !$past(quad_enable_bit) && !$past(quad_data_line_three, 4)
    && !$past(quad_data_line_three, 40)) else $error("abort without long restart pulse");
  op_excl_a: assert property (!(op_valid_ff && op_refused_ff))
    else $error("operation both issued and refused");
  refuse_pulse_a: assert property (op_refused_ff |=> !op_refused_ff)
    else $error("refusal pulse longer than one cycle");
  op_pulse_a: assert property (op_valid_ff |=> !op_valid_ff)
    else $error("operation pulse longer than one cycle");
  sect_align_a: assert property (op_valid_ff && op_kind_ff == sfr_pkg::OP_SECT_ERASE
    |-> op_addr_ff[11:0] == 12'h000) else $error("sector erase address not aligned");
  blk_align_a: assert property (op_valid_ff && op_kind_ff == sfr_pkg::OP_BLK_ERASE
    |-> op_addr_ff[15:0] == 16'h0000) else $error("block erase address not aligned");
  sec_lock_a: assert property (op_valid_ff && (op_kind_ff == sfr_pkg::OP_SEC_ERASE
    || op_kind_ff == sfr_pkg::OP_SEC_PROG) |-> op_sec_idx_ff != 2'h0
    && !sec_lock_bits[op_sec_idx_ff]) else $error("security op on locked register");
  pause_float_a: assert property (paused_ff && $past(paused_ff) |-> so_oe_n_ff)
    else $error("output driven during pause");
  pause_cause_a: assert property (paused_ff |-> !$past(pin_function_select_bit)
    && !$past(quad_enable_bit)) else $error("pause with wrong pin function");
  desel_float_a: assert property (cs_n_pin [*5] |-> so_oe_n_ff)
    else $error("output driven while deselected");
endmodule : sfr_core_chk

bind sfr_core sfr_core_chk chk_u (
  .ref_clk(ref_clk), .rstn(rstn), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
  .serial_in_pin(serial_in_pin), .quad_data_line_three(quad_data_line_three),
  .so_pin_ff(so_pin_ff), .so_oe_n_ff(so_oe_n_ff),
  .pin_function_select_bit(pin_function_select_bit), .quad_enable_bit(quad_enable_bit),
  .sec_lock_bits(sec_lock_bits), .abort_ff(abort_ff), .paused_ff(paused_ff),
  .op_valid_ff(op_valid_ff), .op_kind_ff(op_kind_ff), .op_addr_ff(op_addr_ff),
  .op_sec_idx_ff(op_sec_idx_ff), .op_clr_mask_ff(op_clr_mask_ff),
  .op_refused_ff(op_refused_ff)
);

// [sfr_host_model.sv]
// Host side of the serial link: select, clock, data in and pin 3.
// Assumes callers enter tasks just after a ref_clk rising edge.
`timescale 1ns/1ps
module sfr_host_model (
  // Clock
  input wire logic ref_clk,
  // Device output
  input wire logic so_pin_ff,
  input wire logic so_oe_n_ff,
  // Host pins
  output logic     cs_n_pin,
  output logic     sclk_pin,
  output logic     serial_in_pin,
  output logic     quad_data_line_three
);
  logic [7:0] rx_byte;
  // Floating device output reads as the inverse of its last bit
  logic       so_line;
  assign so_line = so_oe_n_ff ? ~so_pin_ff : so_pin_ff;

  initial begin
    cs_n_pin = 1'h1;
    sclk_pin = 1'h0;
    serial_in_pin = 1'h0;
    quad_data_line_three = 1'h1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic select_dev();
    cs_n_pin <= 1'h0;
    tick(4);
  endtask : select_dev

  // Released data line shows the inverse of its last bit
  task automatic release_dev();
    sclk_pin <= 1'h0;
    cs_n_pin <= 1'h1;
    serial_in_pin <= ~serial_in_pin;
    tick(8);
  endtask : release_dev

  // Mode 0, 160 ns period; read bit taken late, device answers slowly
  task automatic xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      if (i < 7) rx_byte = {rx_byte[6:0], so_line};
      sclk_pin <= 1'h0;
      serial_in_pin <= tx[i];
      tick(4);
      sclk_pin <= 1'h1;
      tick(4);
    end
    rx_byte = {rx_byte[6:0], so_line};
  endtask : xfer

  task automatic pin3_set(input logic v, input int n);
    quad_data_line_three <= v;
    tick(n);
  endtask : pin3_set
endmodule : sfr_host_model

// [test_sfr_core.sv]
// Self-checking bench for sfr_core driven through the host model.
// Assumes 50 MHz ref_clk; lock bits start with register 2 locked.
`timescale 1ns/1ps
module test_sfr_core;
  logic             ref_clk = 1'h0;
  logic             rstn = 1'h0;
  logic             pin_function_select_bit = 1'h0;
  logic             quad_enable_bit = 1'h0;
  logic [3:1]       sec_lock_bits = 3'h2;
  logic             cs_n_pin, sclk_pin, serial_in_pin, quad_data_line_three;
  logic             so_pin_ff, so_oe_n_ff, abort_ff, paused_ff, op_valid_ff, op_refused_ff;
  sfr_pkg::sfr_op_t op_kind_ff, last_kind;
  logic [21:0]      op_addr_ff, last_addr;
  logic [1:0]       op_sec_idx_ff, last_idx;
  logic [7:0]       op_clr_mask_ff, last_mask;
  int               err_count = 0, total_checks = 0, n_ops = 0, n_ref = 0, n_abort = 0;

  always #10 ref_clk = ~ref_clk;

  sfr_core dut_u (.ref_clk(ref_clk), .rstn(rstn), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .serial_in_pin(serial_in_pin), .quad_data_line_three(quad_data_line_three),
    .so_pin_ff(so_pin_ff), .so_oe_n_ff(so_oe_n_ff),
    .pin_function_select_bit(pin_function_select_bit), .quad_enable_bit(quad_enable_bit),
    .sec_lock_bits(sec_lock_bits), .abort_ff(abort_ff), .paused_ff(paused_ff),
    .op_valid_ff(op_valid_ff), .op_kind_ff(op_kind_ff), .op_addr_ff(op_addr_ff),
    .op_sec_idx_ff(op_sec_idx_ff), .op_clr_mask_ff(op_clr_mask_ff),
    .op_refused_ff(op_refused_ff));
  sfr_host_model host_u (.ref_clk(ref_clk), .so_pin_ff(so_pin_ff), .so_oe_n_ff(so_oe_n_ff),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .serial_in_pin(serial_in_pin),
    .quad_data_line_three(quad_data_line_three));

  // Pulses are one cycle wide, so count them at every edge
  always @(posedge ref_clk) begin
    if (op_valid_ff === 1'h1) begin
      n_ops++;
      last_kind = op_kind_ff;
      last_addr = op_addr_ff;
      last_idx = op_sec_idx_ff;
      last_mask = op_clr_mask_ff;
    end
    if (op_refused_ff === 1'h1) n_ref++;
    if (abort_ff === 1'h1) n_abort++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic send(input logic [7:0] op, input logic [23:0] a);
    host_u.select_dev();
    host_u.xfer(op);
    host_u.xfer(a[23:16]);
    host_u.xfer(a[15:8]);
    host_u.xfer(a[7:0]);
    host_u.tick(6);
  endtask : send

  task automatic done();
    host_u.tick(6);
    host_u.release_dev();
  endtask : done

  task automatic t_erase();
    int n0;
    n0 = n_ops;
    send(sfr_pkg::CMD_SECTOR_ERASE, 24'h3FF123);
    done();
    check("sector kind", last_kind, sfr_pkg::OP_SECT_ERASE);
    check("sector addr", last_addr, 22'h3FF000);
    send(sfr_pkg::CMD_BLOCK_ERASE, 24'h3E5678);
    done();
    check("block kind", last_kind, sfr_pkg::OP_BLK_ERASE);
    check("block addr", last_addr, 22'h3E0000);
    host_u.select_dev();
    host_u.xfer(sfr_pkg::CMD_CHIP_ERASE);
    done();
    check("chip kind", last_kind, sfr_pkg::OP_CHIP_ERASE);
    check("erase count", n_ops - n0, 32'h3);
  endtask : t_erase

  task automatic t_prog();
    int n0;
    n0 = n_ops;
    send(sfr_pkg::CMD_PAGE_PROG, 24'h0012FF);
    host_u.xfer(8'hA5);
    host_u.xfer(8'h3C);
    done();
    check("prog count", n_ops - n0, 32'h2);
    check("prog wrap addr", last_addr, 22'h001200);
    check("prog mask", last_mask, 8'hC3);
  endtask : t_prog

  task automatic t_sec();
    int n0;
    int r0;
    n0 = n_ops;
    r0 = n_ref;
    send(sfr_pkg::CMD_SEC_PROG, 24'h002010);
    host_u.xfer(8'h00);
    done();
    check("locked refused", n_ref > r0, 32'h1);
    check("locked no op", n_ops - n0, 32'h0);
    send(sfr_pkg::CMD_SEC_ERASE, 24'h003000);
    done();
    check("sec3 kind", last_kind, sfr_pkg::OP_SEC_ERASE);
    check("sec3 idx", last_idx, 2'h3);
    r0 = n_ref;
    send(sfr_pkg::CMD_SEC_ERASE, 24'h000000);
    done();
    check("param erase refused", n_ref - r0, 32'h1);
    send(sfr_pkg::CMD_SEC_PROG, 24'h001005);
    host_u.xfer(8'h0F);
    done();
    check("sec1 kind", last_kind, sfr_pkg::OP_SEC_PROG);
    check("sec1 idx", last_idx, 2'h1);
    check("sec1 mask", last_mask, 8'hF0);
    check("sec op count", n_ops - n0, 32'h2);
    // Lock moves to register 1 only
    sec_lock_bits <= 3'h1;
    send(sfr_pkg::CMD_SEC_ERASE, 24'h001000);
    done();
    check("sec1 locked", n_ref - r0, 32'h2);
    send(sfr_pkg::CMD_SEC_ERASE, 24'h002000);
    done();
    check("sec2 unlocked idx", last_idx, 2'h2);
    check("sec2 op count", n_ops - n0, 32'h3);
  endtask : t_sec

  task automatic t_read();
    logic [7:0] ptr;
    send(sfr_pkg::CMD_READ_PARAM, 24'h00000C);
    host_u.xfer(8'h00);
    host_u.xfer(8'h00);
    ptr = host_u.rx_byte;
    done();
    check("table pointer", ptr, sfr_pkg::PARAM_TBL_BASE);
    send(sfr_pkg::CMD_READ_PARAM, {16'h0000, ptr + 8'h01});
    host_u.xfer(8'h00);
    host_u.xfer(8'h00);
    done();
    check("table byte", host_u.rx_byte, sfr_pkg::CMD_SECTOR_ERASE);
    send(sfr_pkg::CMD_READ_PARAM, 24'h000070);
    host_u.xfer(8'h00);
    host_u.xfer(8'h00);
    check("param 70h", host_u.rx_byte, 8'hFF);
    check("read drives", so_oe_n_ff, 1'h0);
    host_u.xfer(8'h00);
    check("param 71h", host_u.rx_byte, 8'hFF);
    host_u.pin3_set(1'h0, 6);
    check("read paused float", so_oe_n_ff, 1'h1);
    host_u.pin3_set(1'h1, 6);
    check("read resumed", so_oe_n_ff, 1'h0);
    done();
  endtask : t_read

  task automatic t_restart();
    int a0;
    int n0;
    pin_function_select_bit <= 1'h1;
    host_u.tick(2);
    a0 = n_abort;
    n0 = n_ops;
    host_u.select_dev();
    host_u.xfer(sfr_pkg::CMD_SECTOR_ERASE);
    host_u.xfer(8'h12);
    host_u.xfer(8'h34);
    host_u.pin3_set(1'h0, 60);
    host_u.pin3_set(1'h1, 6);
    check("abort count", n_abort - a0, 32'h1);
    host_u.xfer(8'h56);
    done();
    check("partial dropped", n_ops - n0, 32'h0);
    host_u.pin3_set(1'h0, 30);
    host_u.pin3_set(1'h1, 6);
    check("short pulse", n_abort - a0, 32'h1);
    quad_enable_bit <= 1'h1;
    host_u.tick(2);
    host_u.pin3_set(1'h0, 60);
    host_u.pin3_set(1'h1, 6);
    check("quad no abort", n_abort - a0, 32'h1);
    quad_enable_bit <= 1'h0;
    send(sfr_pkg::CMD_SECTOR_ERASE, 24'h010ABC);
    done();
    check("fresh select op", n_ops - n0, 32'h1);
    check("fresh select addr", last_addr, 22'h010000);
  endtask : t_restart

  task automatic t_pause();
    int n0;
    pin_function_select_bit <= 1'h0;
    host_u.tick(2);
    n0 = n_ops;
    host_u.select_dev();
    host_u.xfer(sfr_pkg::CMD_SECTOR_ERASE);
    host_u.xfer(8'h2A);
    host_u.pin3_set(1'h0, 6);
    check("paused", paused_ff, 1'h1);
    check("paused float", so_oe_n_ff, 1'h1);
    host_u.xfer(8'hFF);
    host_u.pin3_set(1'h1, 6);
    host_u.xfer(8'hBC);
    host_u.xfer(8'hDE);
    done();
    check("resume op", n_ops - n0, 32'h1);
    check("resume addr", last_addr, 22'h2AB000);
    quad_enable_bit <= 1'h1;
    host_u.select_dev();
    host_u.pin3_set(1'h0, 8);
    check("quad no pause", paused_ff, 1'h0);
    host_u.pin3_set(1'h1, 4);
    done();
    quad_enable_bit <= 1'h0;
  endtask : t_pause

  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'h1;
    host_u.tick(4);
    t_erase();
    t_prog();
    t_sec();
    t_read();
    t_restart();
    t_pause();
    close_out();
  end

  // About 5000 cycles expected; allow ample margin
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    close_out();
  end
endmodule : test_sfr_core
